// ==== design/pbsc_regs.vh ====
`ifndef PBSC_REGS_VH
`define PBSC_REGS_VH

// Clock rate and hold threshold
`define PBSC_CLK_HZ 10000000
`define PBSC_HOLD_MS 4000
`define PBSC_HOLD_CYC ((`PBSC_CLK_HZ / 1000) * `PBSC_HOLD_MS)
// Debounce time in microseconds
`define PBSC_DEB_US 10000
`define PBSC_DEB_CYC ((`PBSC_CLK_HZ / 1000000) * `PBSC_DEB_US)

// Power state encodings on o_pwr_state
`define PBSC_ST_OFF 4'h1
`define PBSC_ST_ON 4'h2
`define PBSC_ST_SLEEP 4'h4

// Sleep depth encodings on i_sleep_type
`define PBSC_SLP_S1 2'h1
`define PBSC_SLP_S3 2'h3
`define PBSC_SLP_S4 2'h0

`endif

// ==== design/pbsc_ctrl.v ====
// Overview of operation
// [R1] Soft-off plus switch press under four seconds powers system to working.
// [R2] Working plus switch press under four seconds moves to soft-off.
// [R3] Working plus switch held over four seconds forces fail-safe soft-off.
// [R4] Sleep: short press wakes to working; long hold goes to soft-off.
// [R5] Operating system soft-off command powers system off, no press needed.
// [R6] Network wake signal powers the system up.
// [R7] Bus activity wakes system only from sleep depths S1 or S3.
// [R8] Switch debounced, hold time counted on standby clock, then compared; the code counts it on i_core_clk.
`timescale 1ns/1ps
`include "pbsc_regs.vh"

module pbsc_ctrl #(
  parameter HOLD_CYC = `PBSC_HOLD_CYC,
  parameter DEB_CYC = `PBSC_DEB_CYC
)(
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_pwr_btn_n,
  input wire i_os_soft_off,
  input wire i_os_sleep,
  input wire [1:0] i_sleep_type,
  input wire i_lan_wake,
  input wire i_usb_wake,
  output reg [3:0] o_pwr_state,
  output reg o_pwr_on,
  output reg o_forced_off
);

  localparam [3:0] ST_OFF = `PBSC_ST_OFF;
  localparam [3:0] ST_ON = `PBSC_ST_ON;
  localparam [3:0] ST_SLEEP = `PBSC_ST_SLEEP;
  localparam [31:0] HOLD_LIM = HOLD_CYC;
  localparam [31:0] DEB_LIM = DEB_CYC;

  // Three-stage synchronisers for pins
  reg [2:0] btn_sync;
  reg [2:0] lan_sync;
  reg [2:0] usb_sync;
  reg btn_raw;
  reg lan_lvl;
  reg usb_lvl;
  reg lan_prev;
  reg usb_prev;

  // Takes the third stage only once the second agrees with it
  function settle;
    input [2:0] sync;
    input lvl;
    begin
      if (sync[1] == sync[2])
        settle = sync[2];
      else
        settle = lvl;
    end
  endfunction

  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      // Released level, so reset shows no false press
      btn_sync <= 3'h7;
      lan_sync <= 3'h0;
      usb_sync <= 3'h0;
      btn_raw <= 1'b0;
      lan_lvl <= 1'b0;
      usb_lvl <= 1'b0;
      lan_prev <= 1'b0;
      usb_prev <= 1'b0;
    end
    else
    begin
      btn_sync <= {btn_sync[1:0], i_pwr_btn_n};
      lan_sync <= {lan_sync[1:0], i_lan_wake};
      usb_sync <= {usb_sync[1:0], i_usb_wake};
      btn_raw <= ~settle(btn_sync, ~btn_raw);
      lan_lvl <= settle(lan_sync, lan_lvl);
      usb_lvl <= settle(usb_sync, usb_lvl);
      lan_prev <= lan_lvl;
      usb_prev <= usb_lvl;
    end
  end

  // Debounce: level must hold DEB_CYC cycles to be accepted
  reg [31:0] deb_cnt;
  reg btn_pressed;
  reg [31:0] hold_cnt;
  reg long_done;

  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      deb_cnt <= 32'h0;
      btn_pressed <= 1'b0;
    end
    // Any bounce restarts the count
    else if (btn_raw == btn_pressed)
      deb_cnt <= 32'h0;
    else if (deb_cnt >= DEB_LIM - 32'h1)
    begin
      deb_cnt <= 32'h0;
      btn_pressed <= btn_raw; // R8
    end
    else
      deb_cnt <= deb_cnt + 32'h1;
  end

  // Exactly the limit already counts as a long hold
  function hold_reached;
    input [31:0] cnt;
    begin
      hold_reached = (cnt >= HOLD_LIM);
    end
  endfunction

  // Long-hold latch keeps the later release from acting again
  wire press_release = ~btn_pressed & (hold_cnt != 32'h0) & ~long_done;
  wire press_long = btn_pressed & ~long_done & hold_reached(hold_cnt);
  // Wake pins act on rising edges; a stuck level wakes once
  wire lan_rise = lan_lvl & ~lan_prev;
  wire usb_rise = usb_lvl & ~usb_prev;

  // Hold timer; a long hold acts at the threshold, not at release
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      hold_cnt <= 32'h0;
      long_done <= 1'b0;
    end
    else if (btn_pressed)
    begin
      if (!hold_reached(hold_cnt))
        hold_cnt <= hold_cnt + 32'h1; // R8
      if (press_long)
        long_done <= 1'b1;
    end
    else
    begin
      hold_cnt <= 32'h0;
      long_done <= 1'b0;
    end
  end

  // Sleep depth latched on entry, decides bus wake eligibility
  reg [1:0] slp_depth;
  reg [3:0] next_state;
  reg next_forced;

  // Bus wake only from the shallow sleep depths
  function bus_wake_ok;
    input [1:0] depth;
    begin
      bus_wake_ok = (depth == `PBSC_SLP_S1) ||
        (depth == `PBSC_SLP_S3);
    end
  endfunction

  always @*
  begin
    next_state = o_pwr_state;
    next_forced = 1'b0;
    case (o_pwr_state)
      ST_OFF:
      begin
        if (press_release)
          next_state = ST_ON; // R1
        else if (lan_rise)
          next_state = ST_ON; // R6
      end
      ST_ON:
      begin
        if (press_long)
        begin
          next_state = ST_OFF; // R3
          next_forced = 1'b1;
        end
        else if (press_release)
          next_state = ST_OFF; // R2
        else if (i_os_soft_off)
          next_state = ST_OFF; // R5
        else if (i_os_sleep)
          next_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (press_long)
          next_state = ST_OFF; // R4
        else if (press_release)
          next_state = ST_ON; // R4
        else if (lan_rise)
          next_state = ST_ON; // R6
        else if (usb_rise && bus_wake_ok(slp_depth))
          next_state = ST_ON; // R7
      end
      default:
        // Stray codes fall back to soft-off
        next_state = ST_OFF;
    endcase
  end

  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_pwr_state <= ST_OFF;
      o_pwr_on <= 1'b0;
      o_forced_off <= 1'b0;
      slp_depth <= `PBSC_SLP_S1;
    end
    else
    begin
      o_pwr_state <= next_state;
      // Decoded from next state so it moves with the state
      o_pwr_on <= (next_state == ST_ON);
      o_forced_off <= next_forced;
      if (o_pwr_state == ST_ON && next_state == ST_SLEEP)
        slp_depth <= i_sleep_type;
    end
  end

endmodule

// ==== testbench/pbsc_panel.sv ====
`timescale 1ns/1ps
module pbsc_panel(
  input wire i_clk,
  output logic o_btn_n
);
  initial
    o_btn_n <= 1'b1;
  // Press for n cycles, release, then settle 20 cycles; the action lands after debounce
  task press(input int n);
    o_btn_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_btn_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask
endmodule

// ==== testbench/pbsc_ctrl_asserts.sv ====
`timescale 1ns/1ps
module pbsc_asserts(
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_pwr_btn_n,
  input wire i_os_soft_off,
  input wire i_os_sleep,
  input wire i_lan_wake,
  input wire i_usb_wake,
  input wire [3:0] o_pwr_state,
  input wire o_pwr_on,
  input wire o_forced_off
);
  wire idle = i_pwr_btn_n && !i_os_soft_off && !i_os_sleep &&
    !i_lan_wake && !i_usb_wake;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  on_tracks_a: assert property (o_pwr_on == (o_pwr_state == 4'h2))
    else $error("pwr_on off state");
  off_no_sleep_a: assert property (o_pwr_state == 4'h1 |=>
    o_pwr_state != 4'h4) else $error("off to sleep");
  os_off_a: assert property (o_pwr_state == 4'h2 && i_os_soft_off |=>
    o_pwr_state == 4'h1) else $error("soft off missed");
  forced_pulse_a: assert property (o_forced_off |=> !o_forced_off)
    else $error("forced too long");
  forced_lands_a: assert property (o_forced_off |-> ##[0:1]
    o_pwr_state == 4'h1) else $error("forced not off");
  lan_wake_a: assert property ($rose(i_lan_wake) && !o_pwr_on |->
    ##[1:10] o_pwr_on) else $error("lan wake missed");
  usb_off_a: assert property ($rose(i_usb_wake) && o_pwr_state == 4'h1
    |=> !o_pwr_on [*8]) else $error("usb woke off");
  idle_stable_a: assert property (idle[*8] ##1 idle[*8] |=>
    $stable(o_pwr_state)) else $error("state moved idle");
  cover property (o_forced_off);
  cover property (o_pwr_state == 4'h4);
  cover property ($rose(o_pwr_on));
endmodule
bind pbsc_ctrl pbsc_asserts pbsc_asserts_inst(.i_core_clk, .i_sys_rst,
  .i_pwr_btn_n, .i_os_soft_off, .i_os_sleep, .i_lan_wake, .i_usb_wake,
  .o_pwr_state, .o_pwr_on, .o_forced_off);

// ==== testbench/tb_pbsc_ctrl.sv ====
`timescale 1ns/1ps
module tb_pbsc_ctrl;
  logic clk = 0;
  logic rst;
  logic os;
  logic slp;
  logic lan;
  logic usb;
  logic seen = 0;
  logic [1:0] typ;
  wire btn_n;
  wire fo;
  wire on;
  wire [3:0] st;
  int errors = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  always @(posedge clk)
    if (fo === 1'b1)
      seen <= 1'b1;
  pbsc_panel pbsc_panel_inst(.i_clk(clk), .o_btn_n(btn_n));
  pbsc_ctrl #(.HOLD_CYC(40), .DEB_CYC(4)) pbsc_ctrl_inst(.i_core_clk(clk),
    .i_sys_rst(rst), .i_pwr_btn_n(btn_n), .i_os_soft_off(os),
    .i_os_sleep(slp), .i_sleep_type(typ), .i_lan_wake(lan),
    .i_usb_wake(usb), .o_pwr_state(st), .o_pwr_on(on), .o_forced_off(fo));
  task chk(input logic [3:0] g, input logic [3:0] e);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt(input logic [3:0] e);
    for (int n = 0; n < 60 && st !== e; n++)
      @(posedge clk);
    chk(st, e);
    chk({3'h0, on}, {3'h0, e == 4'h2});
  endtask
  task sleep(input logic [1:0] t);
    typ <= t;
    slp <= 1;
    @(posedge clk);
    slp <= 0;
    wt(4'h4);
  endtask
  task summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    rst <= 1'b1;
    os <= 1'b0;
    slp <= 1'b0;
    lan <= 1'b0;
    usb <= 1'b0;
    typ <= 2'h0;
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk({3'h0, on}, 4'h0);
    wt(4'h1);
    pbsc_panel_inst.press(2);
    wt(4'h1);
    pbsc_panel_inst.press(10);
    wt(4'h2);
    pbsc_panel_inst.press(10);
    wt(4'h1);
    chk({3'h0, seen}, 4'h0);
    pbsc_panel_inst.press(60);
    wt(4'h1);
    lan <= 1;
    wt(4'h2);
    lan <= 0;
    pbsc_panel_inst.press(60);
    wt(4'h1);
    chk({3'h0, seen}, 4'h1);
    lan <= 1;
    wt(4'h2);
    lan <= 0;
    sleep(2'h3);
    usb <= 1;
    wt(4'h2);
    usb <= 0;
    sleep(2'h0);
    usb <= 1;
    repeat (20) @(posedge clk);
    wt(4'h4);
    usb <= 0;
    pbsc_panel_inst.press(10);
    wt(4'h2);
    sleep(2'h1);
    usb <= 1;
    wt(4'h2);
    usb <= 0;
    sleep(2'h1);
    pbsc_panel_inst.press(60);
    wt(4'h1);
    lan <= 1;
    wt(4'h2);
    os <= 1;
    @(posedge clk);
    os <= 0;
    wt(4'h1);
    usb <= 1;
    repeat (20) @(posedge clk);
    wt(4'h1);
    summarize();
  end
endmodule
